// ### hw/spk_output_path.sv
// Purpose: speaker output path: staging, output word, control, rate
// Assumes: register port with read data one cycle after the strobe
// Notes: dma words arrive as a request/acknowledge pair
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module spk_output_path #(
    parameter int PAGE_WORDS = spk_pkg::PAGE_WORDS
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [27:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [15:0] RDATA,
    output logic DMA_REQ,
    input wire logic DMA_ACK,
    input wire logic [15:0] DMA_DATA,
    output logic [9:0] DAC_SAMPLE,
    output logic DAC_LOAD,
    output logic DAC_VREF_EN,
    output logic IRQ
);
    localparam int PCNT_W = $clog2(2 * PAGE_WORDS) + 1;

    logic [1:0] rst_sync_q;
    logic rst_n;
    spk_pkg::spk_bus_s bus;
    logic [9:0] staged_q, staged_d, outw_q, outw_d;
    logic staged_full_q, staged_full_d, out_full_q, out_full_d;
    logic vref_q, vref_d, stop_sel_q, stop_sel_d, enable_q, enable_d;
    logic [2:0] rate_q, rate_d;
    logic [spk_pkg::IRQ_W-1:0] stat_q, stat_d, mask_q, mask_d;
    logic [PCNT_W-1:0] pcnt_q, pcnt_d;
    spk_pkg::spk_state_e st_q, st_d;
    logic [15:0] rdata_d;
    logic req_d, load_d, irq_d, tick, running;
    logic take;
    logic [spk_pkg::IRQ_W-1:0] ev;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};
    // running is the state itself, so a halted path reads as stopped
    assign running = (st_q == spk_pkg::SPK_RUN);

    spk_rate_tick u_tick (
        .clk(CLK),
        .rst_n(rst_n),
        .run(running),
        .rate_sel(rate_q),
        .tick(tick)
    );

    always_comb begin
        staged_d = staged_q;
        staged_full_d = staged_full_q;
        outw_d = outw_q;
        out_full_d = out_full_q;
        vref_d = vref_q;
        stop_sel_d = stop_sel_q;
        enable_d = enable_q;
        rate_d = rate_q;
        mask_d = mask_q;
        stat_d = stat_q;
        pcnt_d = pcnt_q;
        st_d = st_q;
        load_d = 1'b0;
        ev = '0;
        // a dma word only lands in an empty staging slot
        take = DMA_REQ && DMA_ACK && !staged_full_q;
        if (take) begin
            staged_d = DMA_DATA[spk_pkg::SMP_W-1:0];
            staged_full_d = 1'b1;
            pcnt_d = pcnt_q + 1'b1;
        end
        if (tick && out_full_q) begin
            load_d = 1'b1;
            out_full_d = 1'b0;
        end
        if (!out_full_d && staged_full_d) begin
            outw_d = staged_d;
            out_full_d = 1'b1;
            staged_full_d = 1'b0;
        end
        unique case (st_q)
            spk_pkg::SPK_IDLE: begin
                if (enable_q) begin
                    st_d = spk_pkg::SPK_RUN;
                    pcnt_d = '0;
                end
            end
            spk_pkg::SPK_RUN: begin
                // only the word that reaches a boundary is an event,
                // otherwise a parked count would re-raise a cleared flag
                if (take && pcnt_d == PCNT_W'(PAGE_WORDS)) begin
                    ev[spk_pkg::IRQ_PAGE_BIT] = 1'b1;
                    if (stop_sel_q) begin
                        st_d = spk_pkg::SPK_HALT;
                        ev[spk_pkg::IRQ_STOP_BIT] = 1'b1;
                    end
                end else if (take && pcnt_d == PCNT_W'(2 * PAGE_WORDS)) begin
                    ev[spk_pkg::IRQ_PAGE_BIT] = 1'b1;
                    st_d = spk_pkg::SPK_HALT;
                    ev[spk_pkg::IRQ_STOP_BIT] = 1'b1;
                end
            end
            spk_pkg::SPK_HALT: begin
                // stays put until software drops and raises the enable
                st_d = spk_pkg::SPK_HALT;
            end
            default: begin
                st_d = spk_pkg::SPK_IDLE;
            end
        endcase
        stat_d = stat_q | ev;
        if (bus.wr) begin
            unique case (bus.addr)
                spk_pkg::ADDR_STAGING: if (enable_q) begin
                    staged_d = bus.wdata[9:0];
                    staged_full_d = 1'b1;
                end
                spk_pkg::ADDR_OUTPUT: if (enable_q) begin
                    outw_d = bus.wdata[9:0];
                    out_full_d = 1'b1;
                end
                spk_pkg::ADDR_CONTROL: begin
                    vref_d = bus.wdata[spk_pkg::CTL_VREF_BIT];
                    stop_sel_d = bus.wdata[spk_pkg::CTL_STOP_BIT];
                end
                spk_pkg::ADDR_RATE: rate_d = bus.wdata[2:0];
                spk_pkg::ADDR_SEQUENCE: begin
                    enable_d = bus.wdata[spk_pkg::SEQ_ENABLE_BIT];
                end
                spk_pkg::ADDR_IRQ_STATUS: begin
                    // an event in the same cycle beats the clear
                    stat_d = stat_d & ~(bus.wdata[spk_pkg::IRQ_W-1:0] & ~ev);
                end
                spk_pkg::ADDR_IRQ_MASK: mask_d = bus.wdata[1:0];
                default: ;
            endcase
        end
        if (!enable_d) begin
            staged_d = spk_pkg::SAMPLE_RESET;
            outw_d = spk_pkg::SAMPLE_RESET;
            staged_full_d = 1'b0;
            out_full_d = 1'b0;
            st_d = spk_pkg::SPK_IDLE;
        end
        req_d = (st_d == spk_pkg::SPK_RUN) && !staged_full_d;
        irq_d = |(stat_d & mask_d);
    end

    always_comb begin
        rdata_d = 16'h0;
        if (bus.rd) begin
            unique case (bus.addr)
                spk_pkg::ADDR_STAGING: rdata_d[9:0] = staged_q;
                spk_pkg::ADDR_OUTPUT: rdata_d[9:0] = outw_q;
                spk_pkg::ADDR_CONTROL: begin
                    rdata_d[spk_pkg::CTL_VREF_BIT] = vref_q;
                    rdata_d[spk_pkg::CTL_RUN_BIT] = running;
                    rdata_d[spk_pkg::CTL_STOP_BIT] = stop_sel_q;
                end
                spk_pkg::ADDR_RATE: rdata_d[2:0] = rate_q;
                spk_pkg::ADDR_SEQUENCE: rdata_d[0] = enable_q;
                spk_pkg::ADDR_IRQ_STATUS: rdata_d[1:0] = stat_q;
                spk_pkg::ADDR_IRQ_MASK: rdata_d[1:0] = mask_q;
                default: rdata_d = 16'h0;
            endcase
        end
    end

    // data path: both sample words, their full flags and the word count
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            staged_q <= spk_pkg::SAMPLE_RESET;
            outw_q <= spk_pkg::SAMPLE_RESET;
            staged_full_q <= 1'b0;
            out_full_q <= 1'b0;
            pcnt_q <= '0;
            st_q <= spk_pkg::SPK_IDLE;
        end else begin
            staged_q <= staged_d;
            outw_q <= outw_d;
            staged_full_q <= staged_full_d;
            out_full_q <= out_full_d;
            pcnt_q <= pcnt_d;
            st_q <= st_d;
        end
    end

    // software-visible control, rate and interrupt state
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            vref_q <= 1'b0;
            stop_sel_q <= 1'b0;
            enable_q <= 1'b0;
            rate_q <= spk_pkg::RATE_11K;
            stat_q <= '0;
            mask_q <= '0;
        end else begin
            vref_q <= vref_d;
            stop_sel_q <= stop_sel_d;
            enable_q <= enable_d;
            rate_q <= rate_d;
            stat_q <= stat_d;
            mask_q <= mask_d;
        end
    end

    // pins come straight from flops so the far side never sees a glitch
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            RDATA <= 16'h0;
            DMA_REQ <= 1'b0;
            DAC_SAMPLE <= spk_pkg::SAMPLE_RESET;
            DAC_LOAD <= 1'b0;
            DAC_VREF_EN <= 1'b0;
            IRQ <= 1'b0;
        end else begin
            RDATA <= rdata_d;
            DMA_REQ <= req_d;
            DAC_SAMPLE <= outw_d;
            DAC_LOAD <= load_d;
            DAC_VREF_EN <= vref_d;
            IRQ <= irq_d;
        end
    end
endmodule : spk_output_path
`default_nettype wire

// ### hw/spk_rate_tick.sv
// Purpose: conversion period timer for the speaker converter
// Assumes: active-low reset from the top, asserted at once and released in step with clk
// Notes: reserved codes fall back to the default 11.025 ksps rate
`timescale 1ns/100ps
`default_nettype none
module spk_rate_tick (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic [2:0] rate_sel,
    output logic tick
);
    logic [spk_pkg::PER_W-1:0] cnt_q, cnt_d, period;
    logic tick_d;

    always_comb begin
        unique case (rate_sel)
            spk_pkg::RATE_22K: period = spk_pkg::PER_22K;
            spk_pkg::RATE_44K: period = spk_pkg::PER_44K;
            spk_pkg::RATE_8K: period = spk_pkg::PER_8K;
            default: period = spk_pkg::PER_11K;
        endcase
        cnt_d = cnt_q;
        tick_d = 1'b0;
        if (!run) begin
            cnt_d = '0;
        end else if (cnt_q >= period - 16'h1) begin
            cnt_d = '0;
            tick_d = 1'b1;
        end else begin
            cnt_d = cnt_q + 16'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
            tick <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick <= tick_d;
        end
    end
endmodule : spk_rate_tick
`default_nettype wire

// ### include/spk_pkg.sv
// Purpose: shared constants and types for the speaker output path
// Assumes: 200 MHz system clock, 16-bit register port
// Notes: offsets are the printed byte addresses
package spk_pkg;
    localparam int unsigned CLK_HZ = 200000000;
    localparam int ADDR_W = 28;
    localparam int DATA_W = 16;
    localparam int SMP_W = 10;
    localparam logic [27:0] ADDR_STAGING = 28'hb000162;
    localparam logic [27:0] ADDR_OUTPUT = 28'hb000166;
    localparam logic [27:0] ADDR_CONTROL = 28'hb000168;
    localparam logic [27:0] ADDR_RATE = 28'hb00016a;
    // sequence and status words are placed after the rate word, the mask word below the staging word
    localparam logic [27:0] ADDR_SEQUENCE = 28'hb00016c;
    localparam logic [27:0] ADDR_IRQ_STATUS = 28'hb00016e;
    localparam logic [27:0] ADDR_IRQ_MASK = 28'hb000160;
    localparam logic [9:0] SAMPLE_RESET = 10'h200;
    localparam int CTL_VREF_BIT = 15;
    localparam int CTL_RUN_BIT = 3;
    localparam int CTL_STOP_BIT = 1;
    localparam int SEQ_ENABLE_BIT = 0;
    localparam int IRQ_W = 2;
    localparam int IRQ_PAGE_BIT = 0;
    localparam int IRQ_STOP_BIT = 1;
    localparam logic [2:0] RATE_11K = 3'h0;
    localparam logic [2:0] RATE_22K = 3'h1;
    localparam logic [2:0] RATE_44K = 3'h2;
    localparam logic [2:0] RATE_8K = 3'h4;
    localparam int unsigned SPS_11K = 11025;
    localparam int unsigned SPS_22K = 22050;
    localparam int unsigned SPS_44K = 44100;
    localparam int unsigned SPS_8K = 8000;
    localparam int PER_W = 16;
    localparam logic [15:0] PER_11K = 16'(CLK_HZ / SPS_11K);
    localparam logic [15:0] PER_22K = 16'(CLK_HZ / SPS_22K);
    localparam logic [15:0] PER_44K = 16'(CLK_HZ / SPS_44K);
    localparam logic [15:0] PER_8K = 16'(CLK_HZ / SPS_8K);
    localparam int PAGE_WORDS = 2048;
    typedef struct packed {
        logic [27:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } spk_bus_s;
    typedef enum logic [1:0] {SPK_IDLE, SPK_RUN, SPK_HALT} spk_state_e;
endpackage : spk_pkg

// ### tb/spk_dma_model.sv
// Purpose: dma controller feeding speaker words
// Assumes: word taken at an edge with request and acknowledge high
// Notes: idle data toggles each cycle between the last word and its inverse
`timescale 1ns/100ps
`default_nettype none
module spk_dma_model (
    input wire logic clk,
    input wire logic req,
    input wire logic stall,
    input wire logic slow,
    output logic ack,
    output logic [15:0] data,
    output logic [7:0] taken
);
    logic [9:0] nxt = 10'h1;
    logic [1:0] dly = 2'h0;
    initial begin
        ack = 1'b0;
        data = 16'h0;
        taken = 8'h0;
    end
    always @(posedge clk) begin
        if (ack) begin
            // withdrawn word is offered again later
            if (req) begin
                taken <= taken + 8'h1;
                nxt <= nxt + 10'h1;
            end
            ack <= 1'b0;
            dly <= 2'h0;
            data <= ~data;
        end else if (req && !stall && (!slow || dly == 2'h3)) begin
            ack <= 1'b1;
            data <= {6'h0, nxt};
        end else begin
            dly <= req ? dly + 2'h1 : 2'h0;
            data <= ~data;
        end
    end
endmodule : spk_dma_model
`default_nettype wire

// ### tb/spk_output_path_sva.sv
// Purpose: port checker for the speaker output path
// Assumes: bound to the top module
// Notes: reads, reference, load pulse
`timescale 1ns/100ps
`default_nettype none
module spk_output_path_sva #(
    parameter int PAGE_WORDS = spk_pkg::PAGE_WORDS
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [27:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [15:0] RDATA,
    input wire logic DMA_REQ,
    input wire logic DMA_ACK,
    input wire logic [9:0] DAC_SAMPLE,
    input wire logic DAC_LOAD,
    input wire logic DAC_VREF_EN,
    input wire logic IRQ
);
    default clocking @(posedge CLK);
    endclocking
    default disable iff (!RST_N);
    logic rc;
    logic wc;
    assign rc = RD && ADDR == spk_pkg::ADDR_CONTROL;
    assign wc = WR && ADDR == spk_pkg::ADDR_CONTROL;
    property p_ctl_rsvd;
        rc |=> RDATA[14:4] == 11'h0 && !RDATA[2] && !RDATA[0];
    endproperty
    a_ctl_rsvd: assert property (p_ctl_rsvd)
        else $error("control reserved bits nonzero");
    property p_data_rsvd;
        RD && (ADDR == spk_pkg::ADDR_STAGING || ADDR == spk_pkg::ADDR_OUTPUT)
            |=> RDATA[15:10] == 6'h0;
    endproperty
    a_data_rsvd: assert property (p_data_rsvd)
        else $error("data reserved bits nonzero");
    property p_rate_rsvd;
        RD && ADDR == spk_pkg::ADDR_RATE |=> RDATA[15:3] == 13'h0;
    endproperty
    a_rate_rsvd: assert property (p_rate_rsvd)
        else $error("rate reserved bits nonzero");
    property p_sample_rd;
        RD && ADDR == spk_pkg::ADDR_OUTPUT |=> RDATA[9:0] == $past(DAC_SAMPLE);
    endproperty
    a_sample_rd: assert property (p_sample_rd)
        else $error("output word differs from converter sample");
    property p_vref_rd;
        rc && !$past(WR) |=> RDATA[15] == $past(DAC_VREF_EN);
    endproperty
    a_vref_rd: assert property (p_vref_rd)
        else $error("reference bit differs from pin");
    property p_vref_set;
        wc && WDATA[15] |-> ##[1:2] DAC_VREF_EN;
    endproperty
    a_vref_set: assert property (p_vref_set)
        else $error("reference not switched on");
    property p_load_pulse;
        DAC_LOAD |=> !DAC_LOAD [*8];
    endproperty
    a_load_pulse: assert property (p_load_pulse)
        else $error("load pulse too long");
    property p_dis_force;
        WR && ADDR == spk_pkg::ADDR_SEQUENCE && !WDATA[0]
            |-> ##[1:2] DAC_SAMPLE == spk_pkg::SAMPLE_RESET;
    endproperty
    a_dis_force: assert property (p_dis_force)
        else $error("sample not forced on disable");
    c_take: cover property (DMA_REQ && DMA_ACK);
    c_load: cover property (DAC_LOAD ##1 !DAC_LOAD);
    c_irq: cover property ($rose(IRQ));
endmodule : spk_output_path_sva
bind spk_output_path spk_output_path_sva #(.PAGE_WORDS(PAGE_WORDS)) u_sva (
    .CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .DMA_REQ(DMA_REQ), .DMA_ACK(DMA_ACK),
    .DAC_SAMPLE(DAC_SAMPLE), .DAC_LOAD(DAC_LOAD),
    .DAC_VREF_EN(DAC_VREF_EN), .IRQ(IRQ)
);
`default_nettype wire

// ### tb/tb_spk_output_path.sv
// Purpose: self-checking bench for the speaker output path
// Assumes: page cut to four words to keep runs short
// Notes: each register access leaves one spare cycle
`timescale 1ns/100ps
`default_nettype none
module tb_spk_output_path;
    localparam logic [27:0] ad_stg = spk_pkg::ADDR_STAGING;
    localparam logic [27:0] ad_out = spk_pkg::ADDR_OUTPUT;
    localparam logic [27:0] ad_ctl = spk_pkg::ADDR_CONTROL;
    localparam logic [27:0] ad_rate = spk_pkg::ADDR_RATE;
    localparam logic [27:0] ad_seq = spk_pkg::ADDR_SEQUENCE;
    localparam logic [27:0] ad_sts = spk_pkg::ADDR_IRQ_STATUS;
    logic clk, rst_n, wr, rd, dma_req, dma_ack, dac_load, vref, irq;
    logic stall, slow, mon;
    logic [27:0] addr;
    logic [15:0] wdata, rdata, dma_data;
    logic [9:0] dac_sample;
    logic [9:0] last = 10'h200;
    logic [9:0] q[$];
    logic [7:0] taken;
    logic [15:0] rates[4] = '{16'h1, 16'h2, 16'h4, 16'h0};
    int error_cnt = 0, check_count = 0, per = 0, lcnt = 0;
    spk_output_path #(.PAGE_WORDS(4)) u_dut (
        .CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
        .RD(rd), .RDATA(rdata), .DMA_REQ(dma_req), .DMA_ACK(dma_ack),
        .DMA_DATA(dma_data), .DAC_SAMPLE(dac_sample), .DAC_LOAD(dac_load),
        .DAC_VREF_EN(vref), .IRQ(irq));
    spk_dma_model u_dma (.clk(clk), .req(dma_req), .stall(stall),
        .slow(slow), .ack(dma_ack), .data(dma_data), .taken(taken));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic reg_wr(input logic [27:0] a, input logic [15:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask : reg_wr
    task automatic reg_rd(input logic [27:0] a, input logic [15:0] exp);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
        @(posedge clk);
    endtask : reg_rd
    task automatic run(input logic [7:0] n, input int p,
                       input logic [15:0] ctl, input logic ie);
        logic [7:0] base;
        reg_wr(ad_seq, 16'h0);
        base = taken;
        q.delete();
        stall <= 1'b0;
        mon <= 1'b1;
        reg_wr(ad_seq, 16'h1);
        for (int i = 0; i < 8 * p && taken - base < n; i++) @(posedge clk);
        repeat (2 * p) @(posedge clk);
        chk({8'h0, taken - base}, {8'h0, n});
        chk(per[15:0], p[15:0]);
        reg_rd(ad_ctl, ctl);
        reg_rd(ad_sts, 16'h3);
        chk({15'h0, irq}, {15'h0, ie});
        reg_wr(ad_sts, 16'h3);
        reg_rd(ad_sts, 16'h0);
        chk({15'h0, irq}, 16'h0);
        mon <= 1'b0;
        stall <= 1'b1;
    endtask : run
    task automatic conclude;
        $display("checks=%0d errors=%0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : conclude
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        repeat (95000) @(posedge clk);
        error_cnt++;
        conclude();
    end
    // each new converter word must be the next word the dma handed over
    always @(posedge clk) begin
        lcnt <= dac_load ? 0 : lcnt + 1;
        if (dac_load) begin
            per <= lcnt + 1;
        end
        if (dma_req && dma_ack) begin
            q.push_back(dma_data[9:0]);
        end
        if (mon && dac_sample != last && dac_sample != 10'h200) begin
            chk({6'h0, dac_sample}, {6'h0, q.pop_front()});
        end
        last <= dac_sample;
    end
    initial begin
        rst_n = 1'b0;
        addr = 28'h0;
        wdata = 16'h0;
        wr = 1'b0;
        rd = 1'b0;
        stall = 1'b1;
        slow = 1'b0;
        mon = 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        reg_rd(ad_ctl, 16'h0);
        reg_rd(ad_rate, 16'h0);
        reg_rd(ad_stg, 16'h200);
        reg_rd(ad_out, 16'h200);
        reg_rd(28'hb000164, 16'h0);
        reg_wr(ad_stg, 16'h0aa);
        reg_rd(ad_stg, 16'h200);
        foreach (rates[i]) begin
            reg_wr(ad_rate, rates[i]);
            reg_rd(ad_rate, rates[i]);
        end
        reg_wr(ad_seq, 16'h1);
        reg_wr(ad_out, 16'h0aa);
        reg_rd(ad_out, 16'h0aa);
        chk({6'h0, dac_sample}, 16'h0aa);
        reg_rd(ad_ctl, 16'h8);
        reg_wr(ad_seq, 16'h0);
        reg_rd(ad_stg, 16'h200);
        reg_rd(ad_out, 16'h200);
        reg_wr(ad_ctl, 16'h8002);
        reg_rd(ad_ctl, 16'h8002);
        chk({15'h0, vref}, 16'h1);
        reg_wr(ad_rate, 16'h1);
        reg_wr(spk_pkg::ADDR_IRQ_MASK, 16'h1);
        run(8'h4, spk_pkg::PER_22K, 16'h8002, 1'b1);
        reg_wr(ad_ctl, 16'h8000);
        reg_wr(ad_rate, 16'h2);
        reg_wr(spk_pkg::ADDR_IRQ_MASK, 16'h0);
        slow <= 1'b1;
        run(8'h8, spk_pkg::PER_44K, 16'h8000, 1'b0);
        reg_wr(ad_ctl, 16'h0);
        chk({15'h0, vref}, 16'h0);
        conclude();
    end
endmodule : tb_spk_output_path
`default_nettype wire
